// ### twd_pkg.sv
// shared constants and types of the two-wire debug register block
`default_nettype none
package twd_pkg;

   // target-select values that pick a data register
   localparam logic [7:0] ADDR_PART_ID    = 8'h00;
   localparam logic [7:0] ADDR_REVISION   = 8'h01;
   localparam logic [7:0] ADDR_UNLOCK     = 8'h02;
   localparam logic [7:0] ADDR_DATA_PORT  = 8'hb4;

   // reset values
   localparam logic [7:0] RESET_ADDRESS   = 8'h00;
   localparam logic [7:0] RESET_UNLOCK    = 8'h00;
   localparam logic [7:0] RESET_DATA_PORT = 8'h00;

   // unlock codes, in the order they must arrive
   localparam logic [7:0] UNLOCK_FIRST    = 8'h02;
   localparam logic [7:0] UNLOCK_SECOND   = 8'h01;

   // flash command codes carried by the data port
   localparam logic [7:0] CMD_BLOCK_READ   = 8'h06;
   localparam logic [7:0] CMD_BLOCK_WRITE  = 8'h07;
   localparam logic [7:0] CMD_PAGE_ERASE   = 8'h08;
   localparam logic [7:0] CMD_DEVICE_ERASE = 8'h03;

   // link frame: start bit, two instruction bits, byte of eight bits
   localparam logic       FRAME_START      = 1'h1;
   localparam logic [1:0] INSTR_DATA_READ  = 2'h0;
   localparam logic [1:0] INSTR_ADDR_WRITE = 2'h1;
   localparam logic [1:0] INSTR_DATA_WRITE = 2'h2;
   localparam logic [1:0] INSTR_ADDR_READ  = 2'h3;
   localparam logic [3:0] INSTR_LAST_BIT   = 4'h1;
   localparam logic [3:0] BYTE_LAST_BIT    = 4'h7;
   localparam logic [3:0] BYTE_BITS        = 4'h8;

   // link-side frame states
   typedef enum logic [2:0] {
      L_IDLE, L_INSTR, L_WDATA, L_WAIT, L_RDATA, L_DONE
   } link_state_t;

   // unlock sequence states
   typedef enum logic [1:0] {
      U_LOCKED, U_ARMED, U_OPEN
   } unlock_state_t;

endpackage
`default_nettype wire

// ### twd_level_sync.sv
// three-stage synchroniser that passes a change once two stages agree
`timescale 1ns/1ps
`default_nettype none
module twd_level_sync #(
   parameter int WIDTH = 1
) (
   // destination clock
   input  wire logic             clk,
   input  wire logic             rst_n,
   // crossing level
   input  wire logic [WIDTH-1:0] d,
   output logic      [WIDTH-1:0] q
);

   logic [WIDTH-1:0] stage1;
   logic [WIDTH-1:0] stage2;
   logic [WIDTH-1:0] stage3;

   if (WIDTH < 1) begin : g_bad_width
      $error("twd_level_sync needs a width of at least one");
   end

   // stage1 feeds only stage2; q moves once stage2 and stage3 agree
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         stage1 <= '0;
         stage2 <= '0;
         stage3 <= '0;
         q      <= '0;
      end else begin
         stage1 <= d;
         stage2 <= stage1;
         stage3 <= stage2;
         if (stage2 == stage3) begin
            q <= stage3;
         end
      end
   end

endmodule
`default_nettype wire

// ### twd_target.sv
// two-wire debug target: link framing, target select, unlock and data port
`timescale 1ns/1ps
`default_nettype none
module twd_target
   import twd_pkg::*;
#(
   parameter logic [7:0] PART_ID = 8'h5a  // arbitrary value, stands in for the family code
) (
   // system clock and reset
   input  wire logic       sys_clk,
   input  wire logic       resetn,
   // system status
   input  wire logic [7:0] revision_code,
   input  wire logic       core_halted,
   // debug link pins
   input  wire logic       debug_clock_line,
   input  wire logic       debug_data_in,
   output logic            debug_data_out,
   output logic            debug_data_oe,
   // flash engine side
   output logic            prog_enable,
   output logic            flash_cmd_valid,
   output logic            flash_arg_valid,
   output logic [7:0]      flash_byte,
   input  wire logic       flash_done,
   input  wire logic       flash_rsp_valid,
   input  wire logic [7:0] flash_rsp_data
);

   // link-domain state
   link_state_t link_state;
   logic [3:0]  bit_cnt;
   logic [1:0]  instr;
   logic [7:0]  shift;
   logic [7:0]  target_select_address;
   logic        req_tog;
   logic        req_write;
   logic [7:0]  req_addr;
   logic [7:0]  req_wdata;
   logic        ack_sync;

   // system-domain state
   logic          req_sync;
   logic          ack_tog;
   logic [7:0]    reply;
   unlock_state_t unlock_state;
   logic [7:0]    programming_unlock_control;
   logic [7:0]    programming_data_port;
   logic          expect_cmd;

   // link-domain decode helpers
   logic [1:0] next_instr;
   logic [7:0] byte_in;
   logic       instr_last;
   logic       byte_last;
   logic       ack_ok;

   assign next_instr = {debug_data_in, instr[1]};
   assign byte_in    = {debug_data_in, shift[7:1]};
   assign instr_last = (link_state == L_INSTR) && (bit_cnt == INSTR_LAST_BIT);
   assign byte_last  = (link_state == L_WDATA) && (bit_cnt == BYTE_LAST_BIT);
   assign ack_ok     = (ack_sync == req_tog);

   // request toggle into sys_clk, acknowledge toggle back to the link
   twd_level_sync #(.WIDTH(1)) u_req_sync (
      .clk   (sys_clk),
      .rst_n (resetn),
      .d     (req_tog),
      .q     (req_sync)
   );

   twd_level_sync #(.WIDTH(1)) u_ack_sync (
      .clk   (debug_clock_line),
      .rst_n (resetn),
      .d     (ack_tog),
      .q     (ack_sync)
   );

   // link frame sequencer; runs only while the host clocks the line
   always_ff @(posedge debug_clock_line or negedge resetn) begin
      if (!resetn) begin
         link_state <= L_IDLE;
         bit_cnt    <= 4'h0;
         instr      <= INSTR_DATA_READ;
         shift      <= 8'h00;
      end else begin
         case (link_state)
            // start bit on the shared line
            L_IDLE: begin
               bit_cnt <= 4'h0;
               if (debug_data_in == FRAME_START) begin
                  link_state <= L_INSTR;
               end
            end
            L_INSTR: begin
               instr   <= next_instr;
               bit_cnt <= bit_cnt + 4'h1;
               if (instr_last) begin
                  bit_cnt <= 4'h0;
                  case (next_instr)
                     INSTR_ADDR_READ: begin
                        shift      <= target_select_address;
                        link_state <= L_RDATA;
                     end
                     INSTR_DATA_READ: link_state <= L_WAIT;
                     default:         link_state <= L_WDATA;
                  endcase
               end
            end
            L_WDATA: begin
               shift   <= byte_in;
               bit_cnt <= bit_cnt + 4'h1;
               if (byte_last) begin
                  bit_cnt <= 4'h0;
                  if (instr == INSTR_ADDR_WRITE) begin
                     link_state <= L_IDLE;
                  end else begin
                     link_state <= L_WAIT;
                  end
               end
            end
            // hold the host in wait until the system side has answered
            L_WAIT: begin
               if (ack_ok) begin
                  if (instr == INSTR_DATA_READ) begin
                     shift      <= reply;
                     link_state <= L_RDATA;
                  end else begin
                     link_state <= L_DONE;
                  end
               end
            end
            L_RDATA: begin
               if (bit_cnt == BYTE_BITS) begin
                  link_state <= L_IDLE;
               end else begin
                  shift   <= {1'h0, shift[7:1]};
                  bit_cnt <= bit_cnt + 4'h1;
               end
            end
            L_DONE:  link_state <= L_IDLE;
            default: link_state <= L_IDLE;
         endcase
      end
   end

   // data line drive: wait bits, ready bit, then the byte lsb first
   always_ff @(posedge debug_clock_line or negedge resetn) begin
      if (!resetn) begin
         debug_data_out <= 1'h0;
         debug_data_oe  <= 1'h0;
      end else begin
         case (link_state)
            L_INSTR: begin
               // drive only after the host has handed over
               if (instr_last && next_instr == INSTR_ADDR_READ) begin
                  debug_data_oe  <= 1'h1;
                  debug_data_out <= 1'h1;
               end else if (instr_last && next_instr == INSTR_DATA_READ) begin
                  debug_data_oe  <= 1'h1;
                  debug_data_out <= 1'h0;
               end
            end
            L_WDATA: begin
               if (byte_last && instr != INSTR_ADDR_WRITE) begin
                  debug_data_oe  <= 1'h1;
                  debug_data_out <= 1'h0;
               end
            end
            L_WAIT: begin
               debug_data_oe  <= 1'h1;
               debug_data_out <= ack_ok;  // low while waiting, high marks ready
            end
            L_RDATA: begin
               if (bit_cnt == BYTE_BITS) begin
                  debug_data_oe  <= 1'h0;
                  debug_data_out <= 1'h0;
               end else begin
                  debug_data_out <= shift[0];
               end
            end
            default: begin
               debug_data_oe  <= 1'h0;
               debug_data_out <= 1'h0;
            end
         endcase
      end
   end

   // target select register lives with the link, it never crosses
   always_ff @(posedge debug_clock_line or negedge resetn) begin
      if (!resetn) begin
         target_select_address <= RESET_ADDRESS;
      end else if (byte_last && instr == INSTR_ADDR_WRITE) begin
         target_select_address <= byte_in;
      end
   end

   // request words are held still from the toggle until the answer returns
   always_ff @(posedge debug_clock_line or negedge resetn) begin
      if (!resetn) begin
         req_tog   <= 1'h0;
         req_write <= 1'h0;
         req_addr  <= RESET_ADDRESS;
         req_wdata <= 8'h00;
      end else if (instr_last && next_instr == INSTR_DATA_READ) begin
         req_addr  <= target_select_address;
         req_write <= 1'h0;
         req_tog   <= ~req_tog;
      end else if (byte_last && instr == INSTR_DATA_WRITE) begin
         req_addr  <= target_select_address;
         req_wdata <= byte_in;
         req_write <= 1'h1;
         req_tog   <= ~req_tog;
      end
   end

   // system-side request decode
   logic take;
   logic wr_unlock;
   logic wr_data;
   logic flash_ok;
   logic is_cmd;

   assign take      = (req_sync != ack_tog);
   // link-only decode, no cpu access path exists
   assign wr_unlock = take && req_write && (req_addr == ADDR_UNLOCK);
   assign wr_data   = take && req_write && (req_addr == ADDR_DATA_PORT);
   // flash work only while the core is halted
   assign flash_ok  = wr_data && prog_enable && core_halted;
   assign is_cmd    = (req_wdata == CMD_BLOCK_READ) || (req_wdata == CMD_BLOCK_WRITE)
                   || (req_wdata == CMD_PAGE_ERASE) || (req_wdata == CMD_DEVICE_ERASE);

   // answer and acknowledge move together, so the reply is stable first
   always_ff @(posedge sys_clk or negedge resetn) begin
      if (!resetn) begin
         ack_tog <= 1'h0;
         reply   <= 8'h00;
      end else if (take) begin
         ack_tog <= req_sync;
         if (!req_write) begin
            case (req_addr)
               ADDR_PART_ID:   reply <= PART_ID;
               ADDR_REVISION:  reply <= revision_code;
               ADDR_UNLOCK:    reply <= programming_unlock_control;
               ADDR_DATA_PORT: reply <= programming_data_port;
               default:        reply <= 8'h00;
            endcase
         end
      end
   end

   // unlock sequence detector
   always_ff @(posedge sys_clk or negedge resetn) begin
      if (!resetn) begin
         unlock_state <= U_LOCKED;
      end else if (wr_unlock) begin
         case (unlock_state)
            U_LOCKED: begin
               if (req_wdata == UNLOCK_FIRST) begin
                  unlock_state <= U_ARMED;
               end
            end
            U_ARMED: begin
               if (req_wdata == UNLOCK_SECOND) begin
                  unlock_state <= U_OPEN;
               end else if (req_wdata != UNLOCK_FIRST) begin
                  unlock_state <= U_LOCKED;
               end
            end
            U_OPEN:  unlock_state <= U_OPEN;
            default: unlock_state <= U_LOCKED;
         endcase
      end
   end

   // programming enable is sticky; only resetn clears it
   always_ff @(posedge sys_clk or negedge resetn) begin
      if (!resetn) begin
         prog_enable <= 1'h0;
      end else if (wr_unlock && unlock_state == U_ARMED && req_wdata == UNLOCK_SECOND) begin
         prog_enable <= 1'h1;
      end
   end

   // unlock control keeps the last byte written for read-back
   always_ff @(posedge sys_clk or negedge resetn) begin
      if (!resetn) begin
         programming_unlock_control <= RESET_UNLOCK;
      end else if (wr_unlock) begin
         programming_unlock_control <= req_wdata;
      end
   end

   // data port: link writes win over a flash response in the same cycle
   always_ff @(posedge sys_clk or negedge resetn) begin
      if (!resetn) begin
         programming_data_port <= RESET_DATA_PORT;
      end else if (wr_data) begin
         programming_data_port <= req_wdata;
      end else if (flash_rsp_valid) begin
         programming_data_port <= flash_rsp_data;
      end
   end

   // hand bytes to the flash engine; unknown command bytes are dropped
   always_ff @(posedge sys_clk or negedge resetn) begin
      if (!resetn) begin
         flash_cmd_valid <= 1'h0;
         flash_arg_valid <= 1'h0;
         flash_byte      <= 8'h00;
      end else begin
         flash_cmd_valid <= flash_ok && expect_cmd && is_cmd;
         flash_arg_valid <= flash_ok && !expect_cmd;
         if (wr_data) begin
            flash_byte <= req_wdata;
         end
      end
   end

   // new command beats a done in the same cycle, else its arguments pass as commands
   always_ff @(posedge sys_clk or negedge resetn) begin
      if (!resetn) begin
         expect_cmd <= 1'h1;
      end else if (flash_ok && expect_cmd && is_cmd) begin
         expect_cmd <= 1'h0;
      end else if (flash_done) begin
         expect_cmd <= 1'h1;
      end
   end

   // checks on the system side
   sequence first_code_s;
      wr_unlock && req_wdata == UNLOCK_FIRST;
   endsequence

   sequence second_code_s;
      wr_unlock && req_wdata == UNLOCK_SECOND;
   endsequence

   arm_first_a: assert property (
      @(posedge sys_clk) disable iff (!resetn)
      (unlock_state == U_LOCKED) ##0 first_code_s |=> unlock_state == U_ARMED)
      else $error("first unlock code did not arm");

   unlock_open_a: assert property (
      @(posedge sys_clk) disable iff (!resetn)
      (unlock_state == U_ARMED) ##0 second_code_s |=> prog_enable ##1 prog_enable)
      else $error("unlock pair did not open programming");

   unlock_early_a: assert property (
      @(posedge sys_clk) disable iff (!resetn)
      $rose(prog_enable) |-> $past(unlock_state) == U_ARMED && $past(wr_unlock)
                              && $past(req_wdata) == UNLOCK_SECOND)
      else $error("programming opened without the unlock pair");

   prog_hold_a: assert property (
      @(posedge sys_clk) disable iff (!resetn)
      prog_enable |=> prog_enable && unlock_state == U_OPEN)
      else $error("programming closed without reset");

   unlock_restart_a: assert property (
      @(posedge sys_clk) disable iff (!resetn)
      wr_unlock && !prog_enable && req_wdata != UNLOCK_FIRST && req_wdata != UNLOCK_SECOND
      |=> !prog_enable && unlock_state == U_LOCKED)
      else $error("bad unlock code did not restart detection");

   data_port_a: assert property (
      @(posedge sys_clk) disable iff (!resetn)
      wr_data |=> programming_data_port == $past(req_wdata))
      else $error("data port write lost");

   part_id_a: assert property (
      @(posedge sys_clk) disable iff (!resetn)
      take && !req_write && req_addr == ADDR_PART_ID |=> reply == PART_ID)
      else $error("part id read wrong");

   revision_a: assert property (
      @(posedge sys_clk) disable iff (!resetn)
      take && !req_write && req_addr == ADDR_REVISION |=> reply == $past(revision_code))
      else $error("revision read wrong");

   ro_ignore_a: assert property (
      @(posedge sys_clk) disable iff (!resetn)
      take && req_write && req_addr == ADDR_PART_ID && !flash_rsp_valid
      |=> $stable(programming_data_port) && $stable(programming_unlock_control))
      else $error("write to read-only select changed state");

   flash_cmd_a: assert property (
      @(posedge sys_clk) disable iff (!resetn)
      flash_ok && expect_cmd && req_wdata == CMD_PAGE_ERASE
      |=> flash_cmd_valid && flash_byte == CMD_PAGE_ERASE ##1 !flash_cmd_valid)
      else $error("page erase command not passed on");

   // checks on the link side
   addr_load_a: assert property (
      @(posedge debug_clock_line) disable iff (!resetn)
      byte_last && instr == INSTR_ADDR_WRITE |=> target_select_address == $past(byte_in))
      else $error("target select not loaded");

   line_turn_a: assert property (
      @(posedge debug_clock_line) disable iff (!resetn)
      (link_state == L_IDLE || link_state == L_INSTR || link_state == L_WDATA)
      |-> !debug_data_oe)
      else $error("data line driven while the host owns it");

endmodule
`default_nettype wire

// ### twd_host_model.sv
// host-side model of the two-wire debug link: link clock and shared data line
`timescale 1ns/1ps
`default_nettype none
module twd_host_model (
   // link pins seen from the host
   output logic      debug_clock_line,
   output logic      debug_data_in,
   input  wire logic debug_data_out,
   input  wire logic debug_data_oe
);
   logic host_drv;
   logic stalled;

   assign debug_data_in = debug_data_oe ? debug_data_out : host_drv;

   initial begin
      debug_clock_line = 1'b0;
      host_drv = 1'b0;
      stalled = 1'b0;
   end

   // one link clock; clock rests low between frames
   task automatic pulse();
      #32 debug_clock_line = 1'b1;
      #32 debug_clock_line = 1'b0;
   endtask

   // data changes while clock is low, far from the rising edge
   task automatic send_bit(input logic b);
      host_drv = b;
      pulse();
   endtask

   task automatic head(input logic [1:0] instr);
      send_bit(1'b1);
      send_bit(instr[0]);
      send_bit(instr[1]);
   endtask

   task automatic send_byte(input logic [7:0] d);
      for (int i = 0; i < 8; i++) send_bit(d[i]);
   endtask

   // device owns the line; inverse shown so a stale level cannot pass
   task automatic wait_ready();
      host_drv = ~host_drv;
      for (int i = 0; i < 40 && !(debug_data_oe === 1'b1 && debug_data_out === 1'b1); i++) pulse();
      if (!(debug_data_oe === 1'b1 && debug_data_out === 1'b1)) stalled = 1'b1;
   endtask

   task automatic get_byte(output logic [7:0] d);
      for (int i = 0; i < 8; i++) begin
         pulse();
         d[i] = debug_data_in;  // the shared line, so an early release shows up
      end
   endtask

   task automatic finish_frame();
      pulse();
      host_drv = 1'b0;
   endtask

   task automatic addr_write(input logic [7:0] a);
      head(2'b01);
      send_byte(a);
      host_drv = 1'b0;
   endtask

   task automatic addr_read(output logic [7:0] a);
      head(2'b11);
      wait_ready();
      get_byte(a);
      finish_frame();
   endtask

   task automatic data_write(input logic [7:0] d);
      head(2'b10);
      send_byte(d);
      wait_ready();
      finish_frame();
   endtask

   task automatic data_read(output logic [7:0] d);
      head(2'b00);
      wait_ready();
      get_byte(d);
      finish_frame();
   endtask
endmodule
`default_nettype wire

// ### two_wire_debug_register_access_test.sv
// self-checking bench of the two-wire debug register block
`timescale 1ns/1ps
`default_nettype none
module two_wire_debug_register_access_test
   import twd_pkg::*;
;
   localparam logic [7:0] TB_PART_ID = 8'h3c;  // arbitrary value
   localparam logic [7:0] TB_REV     = 8'h47;
   localparam logic [7:0] BAD [4]    = '{8'h01, 8'h02, 8'h03, 8'h01};
   localparam logic [7:0] CMDS [4]   = '{CMD_BLOCK_READ, CMD_BLOCK_WRITE, CMD_PAGE_ERASE, CMD_DEVICE_ERASE};

   logic       sys_clk, resetn, core_halted, flash_done, flash_rsp_valid;
   logic [7:0] revision_code, flash_rsp_data, v;
   wire logic  debug_clock_line, debug_data_in, debug_data_out, debug_data_oe;
   wire logic  prog_enable, flash_cmd_valid, flash_arg_valid;
   wire logic [7:0] flash_byte;
   int         mismatches, checks, cycles, cmd_count, arg_count, c0, a0;

   twd_target #(.PART_ID(TB_PART_ID)) i_twd_target (
      .sys_clk(sys_clk), .resetn(resetn), .revision_code(revision_code), .core_halted(core_halted),
      .debug_clock_line(debug_clock_line), .debug_data_in(debug_data_in),
      .debug_data_out(debug_data_out), .debug_data_oe(debug_data_oe), .prog_enable(prog_enable),
      .flash_cmd_valid(flash_cmd_valid), .flash_arg_valid(flash_arg_valid), .flash_byte(flash_byte),
      .flash_done(flash_done), .flash_rsp_valid(flash_rsp_valid), .flash_rsp_data(flash_rsp_data));

   twd_host_model i_twd_host_model (
      .debug_clock_line(debug_clock_line), .debug_data_in(debug_data_in),
      .debug_data_out(debug_data_out), .debug_data_oe(debug_data_oe));

   initial begin
      sys_clk = 1'b0;
      forever #2.5 sys_clk = ~sys_clk;
   end

   // pulse counters and a hang guard; data frames take about 220 cycles each
   always @(posedge sys_clk) begin
      if (flash_cmd_valid === 1'b1) cmd_count++;
      if (flash_arg_valid === 1'b1) arg_count++;
      cycles++;
      if (cycles == 40000) begin
         mismatches++;
         report_and_stop();
      end
   end

   task automatic check(input logic [7:0] seen, input logic [7:0] exp);
      checks++;
      if (seen !== exp) begin
         mismatches++;
         $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask

   task automatic report_and_stop();
      $display("checks %0d mismatches %0d", checks, mismatches);
      if (mismatches == 0 && checks > 0) $display("STATUS OK");
      else $display("STATUS NOT OK");
      $finish;
   endtask

   task automatic reg_write(input logic [7:0] a, input logic [7:0] d);
      i_twd_host_model.addr_write(a);
      i_twd_host_model.data_write(d);
   endtask

   task automatic reg_read(input logic [7:0] a, output logic [7:0] d);
      i_twd_host_model.addr_write(a);
      i_twd_host_model.data_read(d);
   endtask

   // data-port write, then the count of command and argument pulses it caused
   task automatic data_byte(input logic [7:0] d, input logic [7:0] ec, input logic [7:0] ea);
      c0 = cmd_count;
      a0 = arg_count;
      i_twd_host_model.data_write(d);
      repeat (4) @(negedge sys_clk);
      check(8'(cmd_count - c0), ec);
      check(8'(arg_count - a0), ea);
   endtask

   task automatic done_pulse();
      @(negedge sys_clk) flash_done = 1'b1;
      @(negedge sys_clk) flash_done = 1'b0;
   endtask

   initial begin
      resetn = 1'b0; core_halted = 1'b0; flash_done = 1'b0; flash_rsp_valid = 1'b0;
      flash_rsp_data = 8'h00; revision_code = TB_REV;
      mismatches = 0; checks = 0; cycles = 0; cmd_count = 0; arg_count = 0;
      repeat (16) @(negedge sys_clk);
      resetn = 1'b1;
      repeat (4) @(negedge sys_clk);
      #7;
      // reset values, read-only registers, unmapped select
      i_twd_host_model.addr_read(v);
      check(v, RESET_ADDRESS);
      i_twd_host_model.data_read(v);
      check(v, TB_PART_ID);
      reg_read(ADDR_REVISION, v);
      check(v, TB_REV);
      reg_write(ADDR_PART_ID, 8'hff);
      reg_read(ADDR_PART_ID, v);
      check(v, TB_PART_ID);
      reg_write(ADDR_REVISION, 8'hff);
      reg_read(ADDR_REVISION, v);
      check(v, TB_REV);
      reg_read(ADDR_DATA_PORT, v);
      check(v, RESET_DATA_PORT);
      reg_read(ADDR_UNLOCK, v);
      check(v, RESET_UNLOCK);
      reg_read(8'h10, v);
      check(v, 8'h00);
      check({7'h00, prog_enable}, 8'h00);
      $display("test 1 done");
      // select round trip and data port while locked
      i_twd_host_model.addr_write(ADDR_DATA_PORT);
      i_twd_host_model.addr_read(v);
      check(v, ADDR_DATA_PORT);
      data_byte(8'ha5, 8'h00, 8'h00);
      i_twd_host_model.data_read(v);
      check(v, 8'ha5);
      $display("test 2 done");
      i_twd_host_model.addr_write(ADDR_UNLOCK);
      for (int i = 0; i < 4; i++) begin
         i_twd_host_model.data_write(BAD[i]);
         check({7'h00, prog_enable}, 8'h00);
      end
      i_twd_host_model.data_write(UNLOCK_FIRST);
      i_twd_host_model.data_write(UNLOCK_FIRST);
      check({7'h00, prog_enable}, 8'h00);
      i_twd_host_model.data_write(UNLOCK_SECOND);
      check({7'h00, prog_enable}, 8'h01);
      i_twd_host_model.data_read(v);
      check(v, UNLOCK_SECOND);
      i_twd_host_model.data_write(8'h00);
      check({7'h00, prog_enable}, 8'h01);
      $display("test 3 done");
      // nothing forwarded while the core runs, then each command and its argument once halted
      i_twd_host_model.addr_write(ADDR_DATA_PORT);
      data_byte(CMD_BLOCK_READ, 8'h00, 8'h00);
      done_pulse();
      @(negedge sys_clk) core_halted = 1'b1;
      for (int i = 0; i < 4; i++) begin
         data_byte(CMDS[i], 8'h01, 8'h00);
         check(flash_byte, CMDS[i]);
         data_byte(8'h11 + 8'(i), 8'h00, 8'h01);
         check(flash_byte, 8'h11 + 8'(i));
         done_pulse();
      end
      data_byte(8'h55, 8'h00, 8'h00);
      $display("test 4 done");
      // engine answer lands in the data port
      @(negedge sys_clk) begin
         flash_rsp_data = 8'hc3;
         flash_rsp_valid = 1'b1;
      end
      @(negedge sys_clk) flash_rsp_valid = 1'b0;
      i_twd_host_model.data_read(v);
      check(v, 8'hc3);
      $display("test 5 done");
      // host ends programming by a system reset
      @(negedge sys_clk) resetn = 1'b0;
      repeat (16) @(negedge sys_clk);
      resetn = 1'b1;
      repeat (4) @(negedge sys_clk);
      check({7'h00, prog_enable}, 8'h00);
      i_twd_host_model.addr_read(v);
      check(v, RESET_ADDRESS);
      reg_read(ADDR_DATA_PORT, v);
      check(v, RESET_DATA_PORT);
      // a different strap must show through, the code is not fixed
      revision_code = 8'h48;
      reg_read(ADDR_REVISION, v);
      check(v, 8'h48);
      check({7'h00, i_twd_host_model.stalled}, 8'h00);
      $display("test 6 done");
      report_and_stop();
   end
endmodule
`default_nettype wire
